// ===== src/core_defs.vh
// How it works
// - Program fetch port and data port are separate and work in the same cycle.
// - Next instruction is prefetched while the current one executes.
// - Thirty-two eight-bit working registers, one-cycle read and write.
// - ALU reads two registers, computes and writes back in one cycle.
// - Register pairs 26/27, 28/29, 30/31 act as 16-bit data pointers.
// - The pair 30/31 also addresses constant bytes in program memory.
// - ALU ops work register-register, register-immediate and single register.
// - Arithmetic updates the status flags from the result.
// - Decoder accepts one-word and two-word instructions, one word per address.
// - Jumps, calls and branches carry a full 16-bit program address.
// - Calls and interrupts push the return address to the data SRAM stack.
// - Stack pointer is read and written as I/O registers; stack sits in SRAM.
// - Global interrupt enable in status; each source has its own vector.
// - Among pending interrupts the lowest vector wins.
// - 64 I/O addresses, reached by I/O access or data addresses 0x20-0x5F.
// - Five data addressing modes: direct, indirect, displacement, pre-dec, post-inc.
// - Idle sleep halts execution; memories, peripherals and interrupts keep running.
// - Power-down keeps registers and stops all clocks until interrupt or reset.
// - Noise-reduction sleep halts the core and all I/O except the converter.
// - Taking an interrupt clears global enable; interrupt return sets it.
// - Return address push lowers stack pointer by two; return raises it by two.
`ifndef CORE_DEFS_VH
`define CORE_DEFS_VH

// ----------------------------------------------------------------
// Bus register offsets and reset values
// ----------------------------------------------------------------
`define APB_CTRL 8'h00
`define APB_STATUS 8'h04
`define APB_STACK 8'h08
`define CTRL_RUN_BIT 0
`define CTRL_RUN_RESET 1'b1

// ----------------------------------------------------------------
// Data space map and core I/O registers
// ----------------------------------------------------------------
`define IO_BASE 16'h0020
`define IO_SPL 6'h3d
`define IO_SPH 6'h3e
`define IO_SREG 6'h3f

// ----------------------------------------------------------------
// Status register bits, reset values and vectors
// ----------------------------------------------------------------
`define FLAG_C 0
`define FLAG_Z 1
`define FLAG_N 2
`define FLAG_V 3
`define FLAG_S 4
`define FLAG_H 5
`define FLAG_I 7
`define SREG_RESET 8'h00
`define FETCH_RESET 16'h0000
`define VEC_SHIFT 1

// ----------------------------------------------------------------
// Sleep modes
// ----------------------------------------------------------------
`define SLP_IDLE 2'h0
`define SLP_ADC 2'h1
`define SLP_DOWN 2'h2

`endif

// ===== src/cpu_core_fetch_execute.v
`timescale 1ns/10ps
`include "core_defs.vh"
module cpu_core_fetch_execute #(
   parameter IRQ_COUNT = 8,
   parameter [15:0] RAM_END = 16'h009f
) (
   input wire SYS_CLK,
   input wire ARST_N,
   output reg [15:0] PM_ADDR,
   input wire [15:0] PM_DATA,
   output reg [15:0] D_ADDR,
   output reg [7:0] D_WDATA,
   output reg D_WE,
   output reg D_RE,
   input wire [7:0] D_RDATA,
   input wire [IRQ_COUNT-1:0] IRQ_REQ,
   output reg [IRQ_COUNT-1:0] IRQ_ACK,
   output reg CPU_HALTED,
   output reg IO_CLK_EN,
   output reg ADC_CLK_EN,
   input wire PSEL,
   input wire PENABLE,
   input wire PWRITE,
   input wire [7:0] PADDR,
   input wire [31:0] PWDATA,
   output reg [31:0] PRDATA,
   output reg PREADY,
   output reg PSLVERR
);

// ----------------------------------------------------------------
// States and opcodes
// ----------------------------------------------------------------
localparam [6:0] S_EXEC = 7'h01;
localparam [6:0] S_LOAD = 7'h02;
localparam [6:0] S_PUSH2 = 7'h04;
localparam [6:0] S_RET1 = 7'h08;
localparam [6:0] S_RET2 = 7'h10;
localparam [6:0] S_LPM = 7'h20;
localparam [6:0] S_SLEEP = 7'h40;

localparam [1:0] MAJ_ALU = 2'h0;
localparam [1:0] MAJ_IMM = 2'h1;
localparam [1:0] MAJ_MEM = 2'h2;
localparam [1:0] MAJ_FLOW = 2'h3;

localparam [3:0] F_JMP = 4'h0;
localparam [3:0] F_CALL = 4'h1;
localparam [3:0] F_RET = 4'h2;
localparam [3:0] F_RETURN_FROM_IRQ_INSTR = 4'h3;
localparam [3:0] F_BR = 4'h4;
localparam [3:0] F_SEI = 4'h5;
localparam [3:0] F_CLI = 4'h6;
localparam [3:0] F_SLEEP = 4'h7;
localparam [3:0] F_IN = 4'h8;
localparam [3:0] F_OUT = 4'h9;
localparam [3:0] F_LPM = 4'ha;

localparam [1:0] D_RF = 2'h0;
localparam [1:0] D_CORE = 2'h1;
localparam [1:0] D_EXT = 2'h2;

// ----------------------------------------------------------------
// Functions
// ----------------------------------------------------------------
// Result in the low byte, new status in the high byte.
function [15:0] alu;
   input [3:0] op;
   input [7:0] a;
   input [7:0] b;
   input [7:0] s;
   reg [8:0] r;
   reg [7:0] f;
   reg [7:0] x;
   reg [7:0] y;
   reg is_add;
   reg is_sub;
   begin
      f = s;
      x = a;
      y = b;
      if (op == 4'h9) begin
         x = 8'h00;
         y = a;
      end
      is_add = (op == 4'h0) || (op == 4'h1);
      is_sub = (op == 4'h2) || (op == 4'h3) || (op == 4'h9);
      case (op)
         4'h0: r = {1'b0, x} + {1'b0, y};
         4'h1: r = {1'b0, x} + {1'b0, y} + {8'h00, s[`FLAG_C]};
         4'h2: r = {1'b0, x} - {1'b0, y};
         4'h3: r = {1'b0, x} - {1'b0, y} - {8'h00, s[`FLAG_C]};
         4'h4: r = {1'b0, a & b};
         4'h5: r = {1'b0, a | b};
         4'h6: r = {1'b0, a ^ b};
         4'h7: r = {1'b0, b};
         4'h8: r = {1'b1, ~a};
         4'h9: r = {1'b0, x} - {1'b0, y};
         4'ha: r = {s[`FLAG_C], a + 8'h01};
         4'hb: r = {s[`FLAG_C], a - 8'h01};
         4'hc: r = {a[0], 1'b0, a[7:1]};
         4'hd: r = {a[0], s[`FLAG_C], a[7:1]};
         4'he: r = {a[0], a[7], a[7:1]};
         default: r = {s[`FLAG_C], a[3:0], a[7:4]};
      endcase
      if (op != 4'h7 && op != 4'hf) begin
         f[`FLAG_C] = r[8];
         f[`FLAG_N] = r[7];
         f[`FLAG_Z] = (r[7:0] == 8'h00);
         if (op == 4'h3)
            f[`FLAG_Z] = s[`FLAG_Z] & (r[7:0] == 8'h00);
         if (is_add) begin
            f[`FLAG_V] = (x[7] & y[7] & ~r[7]) | (~x[7] & ~y[7] & r[7]);
            f[`FLAG_H] = (x[3] & y[3]) | (y[3] & ~r[3]) | (~r[3] & x[3]);
         end else if (is_sub) begin
            f[`FLAG_V] = (x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7]);
            f[`FLAG_H] = (~x[3] & y[3]) | (y[3] & r[3]) | (r[3] & ~x[3]);
         end else if (op == 4'ha) begin
            f[`FLAG_V] = (r[7:0] == 8'h80);
         end else if (op == 4'hb) begin
            f[`FLAG_V] = (r[7:0] == 8'h7f);
         end else if (op >= 4'hc) begin
            f[`FLAG_V] = r[7] ^ r[8];
         end else begin
            f[`FLAG_V] = 1'b0;
         end
         f[`FLAG_S] = f[`FLAG_N] ^ f[`FLAG_V];
      end
      alu = {f, r[7:0]};
   end
endfunction

// Sorts a data address into register file, core I/O or outside bus.
function [1:0] dspace;
   input [15:0] a;
   reg [15:0] o;
   begin
      o = a - `IO_BASE;
      if (a < `IO_BASE)
         dspace = D_RF;
      else if (a < `IO_BASE + 16'h0040 && (o[5:0] == `IO_SPL ||
            o[5:0] == `IO_SPH || o[5:0] == `IO_SREG))
         dspace = D_CORE;
      else
         dspace = D_EXT;
   end
endfunction

// ----------------------------------------------------------------
// State
// ----------------------------------------------------------------
reg [7:0] rf [0:31];
reg [6:0] state_reg;
reg [15:0] ir_reg;
reg ir_valid_reg;
reg [15:0] program_counter_reg;
reg [15:0] stack_top_pointer;
reg [15:0] ret_reg;
reg [7:0] ret_hi_reg;
reg return_from_irq_instr_reg;
reg [7:0] sreg_reg;
reg [4:0] ld_rd_reg;
reg lpm_hi_reg;
reg run_reg;

wire [1:0] maj = ir_reg[15:14];
wire [3:0] fop = ir_reg[13:10];
wire [4:0] pi = 5'd26 + {2'b00, ir_reg[10:9], 1'b0};
wire [15:0] pval = {rf[pi + 5'd1], rf[pi]};
wire [15:0] zval = {rf[31], rf[30]};
wire irq_any = |IRQ_REQ;
wire run_ok = (state_reg == S_EXEC) && run_reg && ir_valid_reg;
wire take_irq = run_ok && sreg_reg[`FLAG_I] && irq_any;
wire ex = run_ok && !take_irq;
wire adv = (state_reg == S_EXEC && run_reg && !take_irq) ||
   state_reg == S_PUSH2;

reg is_mem;
reg is_st;
reg two_word;
reg [4:0] m_reg;
reg [15:0] ea;
reg [15:0] io_off;
reg [1:0] cls;
reg [7:0] io_val;
reg pp_en;
reg [15:0] pp_val;
reg alu_en;
reg [3:0] alu_op;
reg [7:0] alu_a;
reg [7:0] alu_b;
reg [4:0] alu_dst;
reg [15:0] alu_out;
reg wr_en;
reg [4:0] wr_idx;
reg [7:0] wr_data;
reg [7:0] irq_idx;
reg [15:0] irq_vec;
reg [IRQ_COUNT-1:0] irq_onehot;
integer i;

// ----------------------------------------------------------------
// Decode and operand path
// ----------------------------------------------------------------
always @* begin
   is_mem = 1'b0;
   is_st = 1'b0;
   two_word = 1'b0;
   m_reg = ir_reg[8:4];
   ea = 16'h0000;
   pp_en = 1'b0;
   pp_val = 16'h0000;
   alu_en = 1'b0;
   alu_op = {ir_reg[10], ir_reg[13:11]};
   alu_a = rf[ir_reg[9:5]];
   alu_b = rf[ir_reg[4:0]];
   alu_dst = ir_reg[9:5];
   case (maj)
      MAJ_ALU: alu_en = 1'b1;
      MAJ_IMM: begin
         alu_en = 1'b1;
         alu_dst = {1'b1, ir_reg[11:8]};
         alu_a = rf[{1'b1, ir_reg[11:8]}];
         alu_b = ir_reg[7:0];
         alu_op = (ir_reg[13:12] == 2'h0) ? 4'h7 :
            (ir_reg[13:12] == 2'h1) ? 4'h2 : {3'b010, ir_reg[12]};
      end
      MAJ_MEM: begin
         is_mem = 1'b1;
         is_st = ir_reg[13];
         if (ir_reg[10:9] == 2'h3) begin
            two_word = 1'b1;
            ea = PM_DATA;
         end else begin
            case (ir_reg[12:11])
               2'h0: ea = pval;
               2'h1: begin
                  ea = pval;
                  pp_en = 1'b1;
                  pp_val = pval + 16'h0001;
               end
               2'h2: begin
                  ea = pval - 16'h0001;
                  pp_en = 1'b1;
                  pp_val = pval - 16'h0001;
               end
               default: ea = pval + {12'h000, ir_reg[3:0]};
            endcase
         end
      end
      default: begin
         if (fop == F_IN || fop == F_OUT) begin
            is_mem = 1'b1;
            is_st = (fop == F_OUT);
            m_reg = {1'b1, ir_reg[9:6]};
            ea = `IO_BASE + {10'h000, ir_reg[5:0]};
         end
         two_word = (fop == F_BR);
      end
   endcase
   io_off = ea - `IO_BASE;
   cls = dspace(ea);
   io_val = (io_off[5:0] == `IO_SPL) ? stack_top_pointer[7:0] :
      (io_off[5:0] == `IO_SPH) ? stack_top_pointer[15:8] : sreg_reg;
   alu_out = alu(alu_op, alu_a, alu_b, sreg_reg);
   wr_en = 1'b0;
   wr_idx = alu_dst;
   wr_data = alu_out[7:0];
   if (state_reg == S_LOAD) begin
      wr_en = 1'b1;
      wr_idx = ld_rd_reg;
      wr_data = D_RDATA;
   end else if (state_reg == S_LPM) begin
      wr_en = 1'b1;
      wr_idx = ld_rd_reg;
      wr_data = lpm_hi_reg ? PM_DATA[15:8] : PM_DATA[7:0];
   end else if (ex && alu_en) begin
      wr_en = 1'b1;
   end else if (ex && is_mem && !is_st && cls != D_EXT) begin
      wr_en = 1'b1;
      wr_idx = m_reg;
      wr_data = (cls == D_RF) ? rf[ea[4:0]] : io_val;
   end
end

// ----------------------------------------------------------------
// Interrupt priority
// ----------------------------------------------------------------
always @* begin
   irq_idx = 8'h00;
   for (i = IRQ_COUNT - 1; i >= 0; i = i - 1)
      if (IRQ_REQ[i])
         irq_idx = i[7:0];
   irq_vec = ({8'h00, irq_idx} + 16'h0001) << `VEC_SHIFT;
   irq_onehot = {{(IRQ_COUNT-1){1'b0}}, 1'b1} << irq_idx;
end

// ----------------------------------------------------------------
// Register file
// ----------------------------------------------------------------
// Left without reset on purpose, so it maps onto plain storage.
always @(posedge SYS_CLK) begin
   if (wr_en)
      rf[wr_idx] <= wr_data;
   if (ex && pp_en) begin
      rf[pi] <= pp_val[7:0];
      rf[pi + 5'd1] <= pp_val[15:8];
   end
end

// ----------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------
always @(posedge SYS_CLK or negedge ARST_N) begin
   if (!ARST_N) begin
      state_reg <= S_EXEC;
      PM_ADDR <= `FETCH_RESET;
      ir_reg <= 16'h0000;
      ir_valid_reg <= 1'b0;
      program_counter_reg <= `FETCH_RESET;
      stack_top_pointer <= RAM_END;
      ret_reg <= 16'h0000;
      ret_hi_reg <= 8'h00;
      return_from_irq_instr_reg <= 1'b0;
      sreg_reg <= `SREG_RESET;
      ld_rd_reg <= 5'h00;
      lpm_hi_reg <= 1'b0;
      D_ADDR <= 16'h0000;
      D_WDATA <= 8'h00;
      D_WE <= 1'b0;
      D_RE <= 1'b0;
      IRQ_ACK <= {IRQ_COUNT{1'b0}};
      CPU_HALTED <= 1'b0;
      IO_CLK_EN <= 1'b1;
      ADC_CLK_EN <= 1'b1;
   end else begin
      D_WE <= 1'b0;
      D_RE <= 1'b0;
      IRQ_ACK <= {IRQ_COUNT{1'b0}};
      // Fetch runs beside execute on its own port.
      if (adv) begin
         ir_reg <= PM_DATA;
         program_counter_reg <= PM_ADDR;
         PM_ADDR <= PM_ADDR + 16'h0001;
         ir_valid_reg <= 1'b1;
      end
      case (state_reg)
         S_EXEC: begin
            if (take_irq) begin
               ir_valid_reg <= 1'b0;
               PM_ADDR <= irq_vec;
               sreg_reg[`FLAG_I] <= 1'b0;
               IRQ_ACK <= irq_onehot;
               ret_reg <= program_counter_reg;
               D_ADDR <= stack_top_pointer;
               D_WDATA <= program_counter_reg[7:0];
               D_WE <= 1'b1;
               state_reg <= S_PUSH2;
            end else if (ex) begin
               if (alu_en)
                  sreg_reg <= alu_out[15:8];
               if (two_word)
                  ir_valid_reg <= 1'b0;
               if (is_mem && cls == D_EXT) begin
                  D_ADDR <= ea;
                  if (is_st) begin
                     D_WDATA <= rf[m_reg];
                     D_WE <= 1'b1;
                  end else begin
                     D_RE <= 1'b1;
                     ld_rd_reg <= m_reg;
                     state_reg <= S_LOAD;
                  end
               end else if (is_mem && is_st && cls == D_CORE) begin
                  if (io_off[5:0] == `IO_SPL)
                     stack_top_pointer[7:0] <= rf[m_reg];
                  else if (io_off[5:0] == `IO_SPH)
                     stack_top_pointer[15:8] <= rf[m_reg];
                  else
                     sreg_reg <= rf[m_reg];
               end
               if (maj == MAJ_FLOW) begin
                  case (fop)
                     F_JMP: begin
                        PM_ADDR <= PM_DATA;
                        ir_valid_reg <= 1'b0;
                     end
                     F_CALL: begin
                        PM_ADDR <= PM_DATA;
                        ir_valid_reg <= 1'b0;
                        ret_reg <= program_counter_reg + 16'h0002;
                        D_ADDR <= stack_top_pointer;
                        D_WDATA <= program_counter_reg[7:0] + 8'h02;
                        D_WE <= 1'b1;
                        state_reg <= S_PUSH2;
                     end
                     F_RET, F_RETURN_FROM_IRQ_INSTR: begin
                        ir_valid_reg <= 1'b0;
                        return_from_irq_instr_reg <= (fop == F_RETURN_FROM_IRQ_INSTR);
                        D_ADDR <= stack_top_pointer + 16'h0001;
                        D_RE <= 1'b1;
                        state_reg <= S_RET1;
                     end
                     F_BR: begin
                        if (sreg_reg[ir_reg[2:0]] == ir_reg[9])
                           PM_ADDR <= PM_DATA;
                     end
                     F_SEI: sreg_reg[`FLAG_I] <= 1'b1;
                     F_CLI: sreg_reg[`FLAG_I] <= 1'b0;
                     F_SLEEP: begin
                        CPU_HALTED <= 1'b1;
                        IO_CLK_EN <= (ir_reg[1:0] == `SLP_IDLE);
                        ADC_CLK_EN <= (ir_reg[1:0] != `SLP_DOWN);
                        state_reg <= S_SLEEP;
                     end
                     F_LPM: begin
                        PM_ADDR <= {1'b0, zval[15:1]};
                        lpm_hi_reg <= zval[0];
                        ld_rd_reg <= ir_reg[4:0];
                        state_reg <= S_LPM;
                     end
                     default: begin
                     end
                  endcase
               end
            end
         end
         S_LOAD: state_reg <= S_EXEC;
         S_PUSH2: begin
            D_ADDR <= stack_top_pointer - 16'h0001;
            D_WDATA <= ret_reg[15:8];
            D_WE <= 1'b1;
            stack_top_pointer <= stack_top_pointer - 16'h0002;
            state_reg <= S_EXEC;
         end
         S_RET1: begin
            ret_hi_reg <= D_RDATA;
            D_ADDR <= stack_top_pointer + 16'h0002;
            D_RE <= 1'b1;
            state_reg <= S_RET2;
         end
         S_RET2: begin
            PM_ADDR <= {ret_hi_reg, D_RDATA};
            stack_top_pointer <= stack_top_pointer + 16'h0002;
            if (return_from_irq_instr_reg)
               sreg_reg[`FLAG_I] <= 1'b1;
            state_reg <= S_EXEC;
         end
         S_LPM: begin
            PM_ADDR <= program_counter_reg + 16'h0001;
            state_reg <= S_EXEC;
         end
         S_SLEEP: begin
            // Any request wakes; it is served only if enabled.
            if (irq_any) begin
               CPU_HALTED <= 1'b0;
               IO_CLK_EN <= 1'b1;
               ADC_CLK_EN <= 1'b1;
               state_reg <= S_EXEC;
            end
         end
         default: state_reg <= S_EXEC;
      endcase
   end
end

// ----------------------------------------------------------------
// Bus slave
// ----------------------------------------------------------------
// One wait state: data are set up, then taken at the ready edge.
always @(posedge SYS_CLK or negedge ARST_N) begin
   if (!ARST_N) begin
      PRDATA <= 32'h00000000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      run_reg <= `CTRL_RUN_RESET;
   end else if (PSEL && PENABLE && !PREADY) begin
      PREADY <= 1'b1;
      PSLVERR <= 1'b0;
      case (PADDR)
         `APB_CTRL: PRDATA <= {31'h00000000, run_reg};
         `APB_STATUS: PRDATA <= {program_counter_reg, sreg_reg,
            6'h00, CPU_HALTED, run_reg};
         `APB_STACK: PRDATA <= {16'h0000, stack_top_pointer};
         default: begin
            PRDATA <= 32'h00000000;
            PSLVERR <= 1'b1;
         end
      endcase
   end else begin
      if (PSEL && PENABLE && PREADY && PWRITE && PADDR == `APB_CTRL)
         run_reg <= PWDATA[`CTRL_RUN_BIT];
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
   end
end

endmodule

// ===== bench/core_props.sv
`timescale 1ns/10ps
`include "core_defs.vh"
module core_props #(
   parameter IRQ_COUNT = 8
) (
   input wire SYS_CLK,
   input wire ARST_N,
   input wire [15:0] PM_ADDR,
   input wire D_WE,
   input wire D_RE,
   input wire [IRQ_COUNT-1:0] IRQ_REQ,
   input wire [IRQ_COUNT-1:0] IRQ_ACK,
   input wire CPU_HALTED,
   input wire IO_CLK_EN,
   input wire ADC_CLK_EN,
   input wire PSEL,
   input wire PENABLE,
   input wire [7:0] PADDR,
   input wire [31:0] PRDATA,
   input wire PREADY,
   input wire PSLVERR
);
   // ----------------------------------------------------------------
   // Port properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!ARST_N);
   sequence s_setup;
      PSEL && !PENABLE;
   endsequence
   sequence s_access;
      PSEL && PENABLE && !PREADY;
   endsequence
   a_apb_wait: assert property (s_setup ##1 s_access |=> PREADY)
      else $error("bus answer late");
   a_bad_offset: assert property (PREADY && PADDR != `APB_CTRL &&
      PADDR != `APB_STATUS && PADDR != `APB_STACK |-> PSLVERR && PRDATA == 0)
      else $error("unmapped offset not refused");
   a_ack_valid: assert property (IRQ_ACK != 0 |->
      $onehot(IRQ_ACK) && (IRQ_ACK & ~$past(IRQ_REQ)) == 0)
      else $error("ack without request");
   a_ack_order: assert property (IRQ_ACK != 0 |->
      ((IRQ_ACK - 1) & $past(IRQ_REQ)) == 0)
      else $error("lower source skipped");
   a_ack_push: assert property (IRQ_ACK != 0 |-> ##[0:2] D_WE)
      else $error("no return push");
   a_awake_clocks: assert property (!CPU_HALTED |->
      IO_CLK_EN && ADC_CLK_EN)
      else $error("clock gated while running");
   // Once asleep the core must not touch either memory port.
   a_sleep_quiet: assert property (CPU_HALTED && $past(CPU_HALTED) |->
      !D_WE && !D_RE && $stable(PM_ADDR))
      else $error("activity in sleep");
   a_irq_wake: assert property (CPU_HALTED && IRQ_REQ != 0 |->
      ##[1:3] !CPU_HALTED)
      else $error("no wake on request");
endmodule
bind cpu_core_fetch_execute core_props #(.IRQ_COUNT(IRQ_COUNT)) u_props (
   .SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PM_ADDR(PM_ADDR), .D_WE(D_WE),
   .D_RE(D_RE), .IRQ_REQ(IRQ_REQ), .IRQ_ACK(IRQ_ACK),
   .CPU_HALTED(CPU_HALTED), .IO_CLK_EN(IO_CLK_EN), .ADC_CLK_EN(ADC_CLK_EN),
   .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR)
);

// ===== bench/mem_model.sv
`timescale 1ns/10ps
module mem_model (
   input wire clk,
   input wire [15:0] pm_addr,
   output wire [15:0] pm_data,
   input wire [15:0] d_addr,
   input wire [7:0] d_wdata,
   input wire d_we,
   input wire d_re,
   output wire [7:0] d_rdata
);
   // ----------------------------------------------------------------
   // Program flash and data space
   // ----------------------------------------------------------------
   reg [15:0] pm [0:255];
   reg [7:0] dm [0:255];
   reg [7:0] last = 8'h00;
   assign pm_data = pm[pm_addr[7:0]];
   // Outside the read cycle the bus shows the inverse of its last value,
   // so a late sample by the core never looks like good data.
   // Read data stand in the cycle in which the read strobe is high.
   assign d_rdata = d_re ? dm[d_addr[7:0]] : ~last;
   always @(posedge clk) begin
      last <= d_rdata;
      if (d_we) begin
         dm[d_addr[7:0]] <= d_wdata;
      end
   end
endmodule

// ===== bench/testbench.sv
`timescale 1ns/10ps
`include "core_defs.vh"
module testbench;
   // ----------------------------------------------------------------
   // Program, bus tasks and checks
   // ----------------------------------------------------------------
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg [7:0] irq_req = 8'h00;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h0;
   wire [15:0] pm_addr, pm_data, d_addr;
   wire [7:0] d_wdata, d_rdata, irq_ack;
   wire d_we, d_re, halted, io_en, adc_en, pready, pslverr;
   wire [31:0] prdata;
   reg [31:0] rd;
   reg e;
   integer n_fail = 0;
   integer n_tests = 0;
   integer cyc = 0;
   integer i;
   always #5 clk = ~clk;
   cpu_core_fetch_execute u_dut (
      .SYS_CLK(clk), .ARST_N(rst_n), .PM_ADDR(pm_addr), .PM_DATA(pm_data),
      .D_ADDR(d_addr), .D_WDATA(d_wdata), .D_WE(d_we), .D_RE(d_re),
      .D_RDATA(d_rdata), .IRQ_REQ(irq_req), .IRQ_ACK(irq_ack),
      .CPU_HALTED(halted), .IO_CLK_EN(io_en), .ADC_CLK_EN(adc_en),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr)
   );
   mem_model u_mem (
      .clk(clk), .pm_addr(pm_addr), .pm_data(pm_data), .d_addr(d_addr),
      .d_wdata(d_wdata), .d_we(d_we), .d_re(d_re), .d_rdata(d_rdata)
   );
   task chk(input [8*8-1:0] name, input [31:0] got, input [31:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected %0s: expected %h, seen %h", name, exp, got);
         end
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] wd);
      integer k;
      begin
         @(posedge clk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= wd;
         @(posedge clk);
         penable <= 1'b1;
         k = 0;
         // Ready, read data and error are taken at the edge that sees ready.
         @(posedge clk);
         while (pready !== 1'b1 && k < 50) begin
            @(posedge clk);
            k = k + 1;
         end
         chk("pready", {31'h0, pready}, 32'h1);
         rd = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task wait_halt;
      integer k;
      begin
         k = 0;
         repeat (2) @(negedge clk);
         while (halted !== 1'b1 && k < 400) begin
            @(negedge clk);
            k = k + 1;
         end
      end
   endtask
   task wake(input [7:0] req, input [7:0] ack_exp);
      integer k;
      begin
         @(posedge clk);
         irq_req <= req;
         k = 0;
         while (irq_ack === 8'h00 && k < 50) begin
            @(negedge clk);
            k = k + 1;
         end
         chk("irq_ack", {24'h0, irq_ack}, {24'h0, ack_exp});
         @(posedge clk);
         irq_req <= req & ~ack_exp;
      end
   endtask
   task tally_and_finish;
      begin
         $display("checks %0d, mismatches %0d", n_tests, n_fail);
         if (n_fail == 0 && n_tests > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   // A hung handshake must still end the run with a verdict.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         n_fail = n_fail + 1;
         tally_and_finish;
      end
   end
   initial begin
      for (i = 0; i < 256; i = i + 1) begin
         u_mem.pm[i] = 16'h0000;
         u_mem.dm[i] = 8'hff;
      end
      u_mem.pm[8'h00] = 16'hc000;
      u_mem.pm[8'h01] = 16'h0020;
      u_mem.pm[8'h02] = 16'hcc00;
      u_mem.pm[8'h06] = 16'hcc00;
      u_mem.pm[8'h0c] = 16'hcc00;
      u_mem.pm[8'h20] = 16'h409f;
      u_mem.pm[8'h21] = 16'he43d;
      u_mem.pm[8'h22] = 16'h4000;
      u_mem.pm[8'h23] = 16'he43e;
      u_mem.pm[8'h24] = 16'h4085;
      u_mem.pm[8'h25] = 16'h417b;
      u_mem.pm[8'h26] = 16'h0211;
      u_mem.pm[8'h27] = 16'ha700;
      u_mem.pm[8'h28] = 16'h0060;
      u_mem.pm[8'h29] = 16'hc400;
      u_mem.pm[8'h2a] = 16'h0040;
      u_mem.pm[8'h2b] = 16'hd400;
      u_mem.pm[8'h2c] = 16'hdc00;
      u_mem.pm[8'h2d] = 16'hdc01;
      u_mem.pm[8'h2e] = 16'hdc02;
      u_mem.pm[8'h2f] = 16'hc000;
      u_mem.pm[8'h30] = 16'h002f;
      u_mem.pm[8'h40] = 16'hc800;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, `APB_STACK, 32'h0);
      chk("stack", rd & 32'hffff, 32'h9f);
      apb(1'b1, 8'h0c, 32'h1);
      chk("slverr", {31'h0, e}, 32'h1);
      apb(1'b1, `APB_CTRL, 32'h0);
      apb(1'b0, `APB_CTRL, 32'h0);
      chk("run_off", rd, 32'h0);
      apb(1'b1, `APB_CTRL, 32'h1);
      apb(1'b0, `APB_CTRL, 32'h0);
      chk("run_on", rd, 32'h1);
      $display("test registers done");
      wait_halt;
      apb(1'b0, `APB_STATUS, 32'h0);
      chk("status", rd & 32'hff03, 32'ha303);
      chk("clocks", {30'h0, io_en, adc_en}, 32'h3);
      chk("store", {24'h0, u_mem.dm[8'h60]}, 32'h0);
      chk("ret_lo", {24'h0, u_mem.dm[8'h9f]}, 32'h2b);
      chk("ret_hi", {24'h0, u_mem.dm[8'h9e]}, 32'h0);
      apb(1'b0, `APB_STACK, 32'h0);
      chk("stack", rd & 32'hffff, 32'h9f);
      $display("test call done");
      wake(8'h24, 8'h04);
      wake(8'h20, 8'h20);
      wait_halt;
      chk("clocks", {30'h0, io_en, adc_en}, 32'h1);
      chk("irq_ret", {24'h0, u_mem.dm[8'h9f]}, 32'h2d);
      $display("test interrupts done");
      wake(8'h01, 8'h01);
      wait_halt;
      chk("clocks", {30'h0, io_en, adc_en}, 32'h0);
      wake(8'h01, 8'h01);
      repeat (8) @(negedge clk);
      chk("halted", {31'h0, halted}, 32'h0);
      apb(1'b0, `APB_STACK, 32'h0);
      chk("stack", rd & 32'hffff, 32'h9f);
      $display("test sleep done");
      tally_and_finish;
   end
endmodule
